//--- logic/tcc_regs.svh
/*
 Register offsets, field positions, reset values and tick masks of the
 16-bit timer/counter. Assumes an 8-bit processor bus with a 4-bit
 location index per timer instance.
*/
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

// ************************************************************
// Register locations
// ************************************************************
`define TCC_ADDR_CTRL_A      4'h0
`define TCC_ADDR_CTRL_B      4'h1
`define TCC_ADDR_COUNT_LO    4'h2
`define TCC_ADDR_COUNT_HI    4'h3
`define TCC_ADDR_CAPTURE_LO  4'h4
`define TCC_ADDR_CAPTURE_HI  4'h5
`define TCC_ADDR_COMPARE_LO  4'h6
`define TCC_ADDR_COMPARE_HI  4'h7
`define TCC_ADDR_FLAGS       4'h8
`define TCC_ADDR_IRQ_EN      4'h9

// ************************************************************
// Field positions
// ************************************************************
`define TCC_A_MODE_LSB       0
`define TCC_B_CLK_LSB        0
`define TCC_B_MODE_LSB       3
`define TCC_B_CMP_SRC        5
`define TCC_B_EDGE_RISE      6
`define TCC_F_OVERFLOW       0
`define TCC_F_CAPTURE        1

// ************************************************************
// Reset values
// ************************************************************
`define TCC_RST_BYTE         8'h00
`define TCC_RST_WORD         16'h0000
`define TCC_RST_FLAGS        2'h0

// ************************************************************
// Fixed top values
// ************************************************************
`define TCC_TOP_8BIT         16'h00ff
`define TCC_TOP_9BIT         16'h01ff
`define TCC_TOP_10BIT        16'h03ff
`define TCC_MAX              16'hffff

// ************************************************************
// Prescaler masks per clock source code
// ************************************************************
`define TCC_PRE_DIV1         10'h000
`define TCC_PRE_DIV8         10'h007
`define TCC_PRE_DIV64        10'h03f
`define TCC_PRE_DIV256       10'h0ff
`define TCC_PRE_DIV1024      10'h3ff

`endif

//--- logic/tcc_pkg.sv
/*
 Types of the 16-bit timer/counter: counting sequences, top sources
 and the processor bus request bundle. Constants live in tcc_regs.svh.
*/
package tcc_pkg;

   // ************************************************************
   // Counting sequence kinds
   // ************************************************************
   typedef enum logic [1:0] {
      TCC_SEQ_CLEAR = 2'b00, // Up, clear at top, overflow at max
      TCC_SEQ_FAST  = 2'b01, // Up, clear at top, overflow at top
      TCC_SEQ_DUAL  = 2'b10  // Up to top, down to zero
   } tcc_seq_t;

   // Source of the top value
   typedef enum logic [2:0] {
      TCC_TOP_MAX  = 3'b000,
      TCC_TOP_8    = 3'b001,
      TCC_TOP_9    = 3'b010,
      TCC_TOP_10   = 3'b011,
      TCC_TOP_CMPA = 3'b100,
      TCC_TOP_CAPT = 3'b101
   } tcc_top_t;

   // Decoded waveform mode
   typedef struct packed {
      tcc_seq_t seq;
      tcc_top_t top;
   } tcc_mode_t;

   // One processor access, one cycle long
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [3:0] addr;
      logic [7:0] wdata;
   } tcc_bus_req_t;

endpackage

//--- logic/tcc_edge.sv
/*
 Pin synchroniser and edge detector. Assumes an asynchronous input pin
 and a reset already synchronised to mclk.
*/
`timescale 1ns/1ns
module tcc_edge (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic pin_in,
   output logic      rise,
   output logic      fall
);

   // ************************************************************
   // Two-stage synchroniser plus history stage
   // ************************************************************
   logic sync_a;   // First stage, read only by sync_b
   logic sync_b;   // Settled level
   logic prev;     // Level one cycle earlier

   // Shift the pin through; the history compares settled levels only
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev   <= 1'b0;
      end else begin
         sync_a <= pin_in;
         sync_b <= sync_a;
         prev   <= sync_b;
      end
   end

   // One-cycle pulses on each settled change
   assign rise = sync_b & ~prev;
   assign fall = ~sync_b & prev;

endmodule

//--- logic/tcc_timer.sv
/*
 16-bit up/down timer/counter with input capture and one shared
 high-byte latch for all 16-bit locations. Assumes a processor core
 issuing at most one single-cycle read or write strobe per cycle, and
 asynchronous capture, comparator and external tick pins.
*/
// Functional notes
// - Counter clears, counts up or down per tick
// - Clock source code zero stops the counter
// - Counter readable and writable at any time
// - Processor write beats counting in same cycle
// - Counter high location reaches only the latch
// - Low read loads latch; low write commits
// - One latch shared by every 16-bit location
// - Latch holds until overwritten
// - Four-bit mode split over control A, B
// - Overflow flag set per mode, requests interrupt
// - Top and zero indications provided
// - Selected capture edge copies counter to capture
// - Comparator source only on first timer
// - Capture flag sets with the capture copy
// - Enabled capture flag interrupts, service clears it
// - Writing one clears capture flag
// - Capture low read loads latch for high
// - Capture writable only in capture-top modes
// - Fixed tops 0x00ff, 0x01ff, 0x03ff, 0xffff, or registers
// - Compare reads bypass the latch
`timescale 1ns/1ns
`include "tcc_regs.svh"
module tcc_timer #(
   parameter int TIMER_INDEX = 1   // 1 is the instance wired to the comparator
) (
   input  wire logic                 mclk,
   input  wire logic                 arst_n,
   input  wire tcc_pkg::tcc_bus_req_t bus_req,
   output logic [7:0]                bus_rdata,
   input  wire logic                 ack_overflow,
   input  wire logic                 ack_capture,
   input  wire logic                 tick_pin,
   input  wire logic                 capture_pin,
   input  wire logic                 comparator_out,
   output logic                      irq_overflow,
   output logic                      irq_capture,
   output logic                      top_hit,
   output logic                      bottom_hit
);

   // Instance numbers outside 1..3 have no meaning
   if (TIMER_INDEX < 1 || TIMER_INDEX > 3) begin : g_bad_index
      $error("TIMER_INDEX must be 1, 2 or 3");
   end

   // ************************************************************
   // Reset release
   // ************************************************************
   logic rst_q;   // First release stage
   logic rst_n;   // Released reset used everywhere

   // Assert at once, release after two edges
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_q <= 1'b1;
         rst_n <= rst_q;
      end
   end

   // ************************************************************
   // State
   // ************************************************************
   logic [7:0]  control_reg_a;   // Mode low bits
   logic [7:0]  control_reg_b;   // Clock source, mode high bits, edge
   logic [15:0] timer_count;     // The counter
   logic [15:0] capture_value;   // Captured counter or top
   logic [15:0] compare_a;       // Compare register A
   logic [7:0]  temp;            // Shared high-byte latch
   logic        dir_up;          // Dual-slope direction
   logic        overflow_flag;   // Sticky overflow
   logic        capture_flag;    // Sticky capture
   logic [1:0]  irq_en;          // Interrupt enables
   logic [9:0]  prescale;        // Free-running prescaler
   logic [15:0] next_count;
   logic        next_dir;
   logic [7:0]  rd_mux;

   // ************************************************************
   // Mode decode
   // ************************************************************
   // Map the four mode bits onto sequence kind and top source
   function automatic tcc_pkg::tcc_mode_t decode_mode(input logic [3:0] w);
      tcc_pkg::tcc_mode_t m;
      m.seq = tcc_pkg::TCC_SEQ_CLEAR;
      m.top = tcc_pkg::TCC_TOP_MAX;
      case (w)
         4'h1:    m = '{tcc_pkg::TCC_SEQ_DUAL,  tcc_pkg::TCC_TOP_8};
         4'h2:    m = '{tcc_pkg::TCC_SEQ_DUAL,  tcc_pkg::TCC_TOP_9};
         4'h3:    m = '{tcc_pkg::TCC_SEQ_DUAL,  tcc_pkg::TCC_TOP_10};
         4'h4:    m = '{tcc_pkg::TCC_SEQ_CLEAR, tcc_pkg::TCC_TOP_CMPA};
         4'h5:    m = '{tcc_pkg::TCC_SEQ_FAST,  tcc_pkg::TCC_TOP_8};
         4'h6:    m = '{tcc_pkg::TCC_SEQ_FAST,  tcc_pkg::TCC_TOP_9};
         4'h7:    m = '{tcc_pkg::TCC_SEQ_FAST,  tcc_pkg::TCC_TOP_10};
         4'h8:    m = '{tcc_pkg::TCC_SEQ_DUAL,  tcc_pkg::TCC_TOP_CAPT};
         4'h9:    m = '{tcc_pkg::TCC_SEQ_DUAL,  tcc_pkg::TCC_TOP_CMPA};
         4'ha:    m = '{tcc_pkg::TCC_SEQ_DUAL,  tcc_pkg::TCC_TOP_CAPT};
         4'hb:    m = '{tcc_pkg::TCC_SEQ_DUAL,  tcc_pkg::TCC_TOP_CMPA};
         4'hc:    m = '{tcc_pkg::TCC_SEQ_CLEAR, tcc_pkg::TCC_TOP_CAPT};
         4'he:    m = '{tcc_pkg::TCC_SEQ_FAST,  tcc_pkg::TCC_TOP_CAPT};
         4'hf:    m = '{tcc_pkg::TCC_SEQ_FAST,  tcc_pkg::TCC_TOP_CMPA};
         default: m = '{tcc_pkg::TCC_SEQ_CLEAR, tcc_pkg::TCC_TOP_MAX};
      endcase
      return m;
   endfunction

   // Mode bits live half in each control register
   wire [3:0] waveform_mode_field = {control_reg_b[`TCC_B_MODE_LSB +: 2],
                                     control_reg_a[`TCC_A_MODE_LSB +: 2]};
   wire tcc_pkg::tcc_mode_t mode = decode_mode(waveform_mode_field);
   wire icr_top = (mode.top == tcc_pkg::TCC_TOP_CAPT);

   // Top value select
   wire [15:0] top_val =
      (mode.top == tcc_pkg::TCC_TOP_8)    ? `TCC_TOP_8BIT  :
      (mode.top == tcc_pkg::TCC_TOP_9)    ? `TCC_TOP_9BIT  :
      (mode.top == tcc_pkg::TCC_TOP_10)   ? `TCC_TOP_10BIT :
      (mode.top == tcc_pkg::TCC_TOP_CMPA) ? compare_a      :
      icr_top                             ? capture_value  : `TCC_MAX;

   // ************************************************************
   // Bus decode
   // ************************************************************
   wire       rd = bus_req.rd;
   wire       wr = bus_req.wr;
   wire [3:0] ad = bus_req.addr;
   wire [7:0] wd = bus_req.wdata;
   wire wr_cnt_lo = wr && ad == `TCC_ADDR_COUNT_LO;
   wire rd_cnt_lo = rd && ad == `TCC_ADDR_COUNT_LO;
   wire wr_cap_lo = wr && ad == `TCC_ADDR_CAPTURE_LO;
   wire rd_cap_lo = rd && ad == `TCC_ADDR_CAPTURE_LO;
   wire wr_cmp_lo = wr && ad == `TCC_ADDR_COMPARE_LO;
   wire wr_flags  = wr && ad == `TCC_ADDR_FLAGS;
   // Every high location write lands in the latch only
   wire wr_any_hi = wr && (ad == `TCC_ADDR_COUNT_HI || ad == `TCC_ADDR_CAPTURE_HI ||
                           ad == `TCC_ADDR_COMPARE_HI);

   // ************************************************************
   // Timer tick select
   // ************************************************************
   logic ext_rise;
   logic ext_fall;
   tcc_edge u_tick_edge (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .pin_in (tick_pin),
      .rise   (ext_rise),
      .fall   (ext_fall)
   );

   wire [2:0] clock_source_select = control_reg_b[`TCC_B_CLK_LSB +: 3];
   wire [9:0] pre_mask =
      (clock_source_select == 3'h2) ? `TCC_PRE_DIV8    :
      (clock_source_select == 3'h3) ? `TCC_PRE_DIV64   :
      (clock_source_select == 3'h4) ? `TCC_PRE_DIV256  :
      (clock_source_select == 3'h5) ? `TCC_PRE_DIV1024 : `TCC_PRE_DIV1;
   // Code zero gives no tick at all
   wire timer_tick =
      (clock_source_select == 3'h0) ? 1'b0     :
      (clock_source_select == 3'h6) ? ext_fall :
      (clock_source_select == 3'h7) ? ext_rise :
      ((prescale & pre_mask) == pre_mask);

   // Prescaler runs free so a source change does not stretch a tick
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) prescale <= 10'h000;
      else        prescale <= prescale + 10'h001;
   end

   // ************************************************************
   // Counting
   // ************************************************************
   // Next counter value; the processor write is applied last
   always_comb begin
      next_count = timer_count;
      next_dir   = dir_up;
      if (timer_tick) begin
         unique case (mode.seq)
            tcc_pkg::TCC_SEQ_CLEAR,
            tcc_pkg::TCC_SEQ_FAST: begin
               if (timer_count == top_val) next_count = `TCC_RST_WORD;
               else                        next_count = timer_count + 16'h0001;
            end
            tcc_pkg::TCC_SEQ_DUAL: begin
               if (dir_up) begin
                  if (timer_count >= top_val) begin
                     next_dir   = 1'b0;
                     next_count = timer_count - 16'h0001;
                  end else begin
                     next_count = timer_count + 16'h0001;
                  end
               end else if (timer_count == `TCC_RST_WORD) begin
                  next_dir   = 1'b1;
                  next_count = timer_count + 16'h0001;
               end else begin
                  next_count = timer_count - 16'h0001;
               end
            end
            default: next_count = timer_count;
         endcase
      end
      // Write wins over counting, tick or not
      if (wr_cnt_lo) next_count = {temp, wd};
   end

   // Overflow point depends on the sequence
   wire ovf_evt = timer_tick && (
      (mode.seq == tcc_pkg::TCC_SEQ_CLEAR && timer_count == `TCC_MAX) ||
      (mode.seq == tcc_pkg::TCC_SEQ_FAST  && timer_count == top_val)  ||
      (mode.seq == tcc_pkg::TCC_SEQ_DUAL  && !dir_up && timer_count == `TCC_RST_WORD));

   // ************************************************************
   // Capture source and edge
   // ************************************************************
   logic pin_rise;   // Capture pin edges
   logic pin_fall;
   logic cmp_rise;   // Comparator edges
   logic cmp_fall;
   // Each source is synchronised on its own, so the select never sees a raw pin
   tcc_edge u_cap_edge (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .pin_in (capture_pin),
      .rise   (pin_rise),
      .fall   (pin_fall)
   );
   tcc_edge u_cmp_edge (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .pin_in (comparator_out),
      .rise   (cmp_rise),
      .fall   (cmp_fall)
   );
   // Comparator path exists on the first instance only
   wire use_cmp  = (TIMER_INDEX == 1) && control_reg_b[`TCC_B_CMP_SRC];
   wire cap_rise = use_cmp ? cmp_rise : pin_rise;
   wire cap_fall = use_cmp ? cmp_fall : pin_fall;
   // Capture is off while the capture register holds the top
   wire cap_edge = control_reg_b[`TCC_B_EDGE_RISE] ? cap_rise : cap_fall;
   wire cap_evt  = cap_edge && !icr_top;

   // ************************************************************
   // Registers
   // ************************************************************
   // Counter, direction and control bytes
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         timer_count   <= `TCC_RST_WORD;
         dir_up        <= 1'b1;
         control_reg_a <= `TCC_RST_BYTE;
         control_reg_b <= `TCC_RST_BYTE;
         compare_a     <= `TCC_RST_WORD;
         irq_en        <= `TCC_RST_FLAGS;
      end else begin
         timer_count <= next_count;
         dir_up      <= next_dir;
         if (wr && ad == `TCC_ADDR_CTRL_A) control_reg_a <= wd;
         if (wr && ad == `TCC_ADDR_CTRL_B) control_reg_b <= wd;
         if (wr && ad == `TCC_ADDR_IRQ_EN) irq_en <= wd[1:0];
         if (wr_cmp_lo) compare_a <= {temp, wd};
      end
   end

   // Capture register: newest event always overwrites
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)                    capture_value <= `TCC_RST_WORD;
      else if (cap_evt)              capture_value <= timer_count;
      else if (wr_cap_lo && icr_top) capture_value <= {temp, wd};
   end

   // Shared latch, one per timer; holds until overwritten
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)         temp <= `TCC_RST_BYTE;
      else if (wr_any_hi) temp <= wd;
      else if (rd_cnt_lo) temp <= timer_count[15:8];
      else if (rd_cap_lo) temp <= capture_value[15:8];
   end

   // Sticky flags; a setting event beats a clear in the same cycle
   wire clr_ovf = (wr_flags && wd[`TCC_F_OVERFLOW]) || ack_overflow;
   wire clr_cap = (wr_flags && wd[`TCC_F_CAPTURE]) || ack_capture;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         overflow_flag <= 1'b0;
         capture_flag  <= 1'b0;
      end else begin
         overflow_flag <= ovf_evt || (overflow_flag && !clr_ovf);
         capture_flag  <= cap_evt || (capture_flag && !clr_cap);
      end
   end

   // ************************************************************
   // Read path and outputs
   // ************************************************************
   // High locations of counter and capture return the latch
   always_comb begin
      unique case (ad)
         `TCC_ADDR_CTRL_A:     rd_mux = control_reg_a;
         `TCC_ADDR_CTRL_B:     rd_mux = control_reg_b;
         `TCC_ADDR_COUNT_LO:   rd_mux = timer_count[7:0];
         `TCC_ADDR_CAPTURE_LO: rd_mux = capture_value[7:0];
         `TCC_ADDR_COMPARE_LO: rd_mux = compare_a[7:0];
         `TCC_ADDR_COMPARE_HI: rd_mux = compare_a[15:8];
         `TCC_ADDR_FLAGS:      rd_mux = {6'h00, capture_flag, overflow_flag};
         `TCC_ADDR_IRQ_EN:     rd_mux = {6'h00, irq_en};
         `TCC_ADDR_COUNT_HI,
         `TCC_ADDR_CAPTURE_HI: rd_mux = temp;
         default:              rd_mux = 8'h00;
      endcase
   end

   // All outputs registered; data follows the read strobe by one cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bus_rdata    <= 8'h00;
         irq_overflow <= 1'b0;
         irq_capture  <= 1'b0;
         top_hit      <= 1'b0;
         bottom_hit   <= 1'b0;
      end else begin
         bus_rdata    <= rd ? rd_mux : 8'h00;
         irq_overflow <= overflow_flag && irq_en[`TCC_F_OVERFLOW];
         irq_capture  <= capture_flag && irq_en[`TCC_F_CAPTURE];
         top_hit      <= timer_count == top_val;
         bottom_hit   <= timer_count == `TCC_RST_WORD;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   wire [7:0] cnt_hi = timer_count[15:8];
   wire [7:0] cmp_hi = compare_a[15:8];
   sequence s_low_write;
      wr_cnt_lo;
   endsequence
   sequence s_capture;
      cap_evt;
   endsequence

   a_write_wins: assert property (s_low_write |=> timer_count == {$past(temp), $past(wd)})
      else $error("Counter low write not committed");
   a_stopped_hold: assert property (clock_source_select == 3'h0 && !wr_cnt_lo
      |=> $stable(timer_count))
      else $error("Counter moved while stopped");
   a_count_step: assert property (timer_tick && mode.seq == tcc_pkg::TCC_SEQ_CLEAR
      && timer_count != top_val && !wr_cnt_lo |=> timer_count == $past(timer_count) + 16'h0001)
      else $error("Counter did not step by one");
   a_latch_read: assert property (rd_cnt_lo && !wr_any_hi |=> temp == $past(cnt_hi))
      else $error("Latch not loaded on low read");
   a_high_only_latch: assert property (wr_any_hi && !timer_tick |=> $stable(timer_count)
      && temp == $past(wd))
      else $error("High write touched counter");
   a_capture_copy: assert property (s_capture |=> capture_value == $past(timer_count)
      && capture_flag)
      else $error("Capture copy or flag missing");
   a_flag_clear: assert property (wr_flags && wd[`TCC_F_CAPTURE] && !cap_evt
      |=> !capture_flag)
      else $error("Capture flag not cleared");
   a_cap_guard: assert property (wr_cap_lo && !icr_top && !cap_evt |=> $stable(capture_value))
      else $error("Capture written outside capture-top mode");
   a_cmp_direct: assert property (rd && ad == `TCC_ADDR_COMPARE_HI && !wr
      |=> bus_rdata == $past(cmp_hi) && $stable(temp))
      else $error("Compare read used latch");
   a_cap_irq: assert property (capture_flag && irq_en[`TCC_F_CAPTURE] && !clr_cap
      && !(wr && ad == `TCC_ADDR_IRQ_EN) |=> irq_capture ##1 irq_capture)
      else $error("Capture interrupt not raised");
   a_ovf_flag: assert property (ovf_evt |=> overflow_flag)
      else $error("Overflow flag not set");

endmodule

//--- verification/tcc_cpu_model.sv
/*
 Processor core model: issues single-cycle register reads and writes.
 Assumes a design that takes strobes on the rising edge of mclk.
*/
`timescale 1ns/1ns
module tcc_cpu_model (
   input  wire logic             mclk,
   input  wire logic [7:0]       bus_rdata,
   output tcc_pkg::tcc_bus_req_t bus_req
);
   // Bus idle until asked; no interrupt preemption, pairs stay atomic
   initial bus_req = '0;

   // One write; callers send the high byte first, then the low
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge mclk) bus_req = '{1'b0, 1'b1, a, d};
      @(negedge mclk) bus_req = '0;
   endtask

   // One read; data lands the cycle after; low read precedes high
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge mclk) bus_req = '{1'b1, 1'b0, a, 8'h00};
      @(negedge mclk) d = bus_rdata;
      bus_req = '0;
   endtask
endmodule

//--- verification/tcc_timer_tb.sv
/*
 Self-checking bench of tcc_timer: table of register accesses, then
 counting and capture cases. Assumes the core model drives the bus.
*/
`timescale 1ns/1ns
module tcc_timer_tb;
   typedef struct {bit w; logic [3:0] a; logic [7:0] d;} tcc_row_t;
   logic                  mclk, arst_n, ack_capture, capture_pin, irq_capture;
   logic                  tick_pin, comparator_out, irq_overflow, top_hit, bottom_hit;
   logic [7:0]            bus_rdata, v, u;
   tcc_pkg::tcc_bus_req_t bus_req;
   int                    err_count = 0, total_checks = 0;
   // Writes carry data, reads carry the expected byte
   tcc_row_t rows [17] = '{
      '{0, 4'h2, 8'h00}, '{0, 4'h5, 8'h00}, '{0, 4'h8, 8'h00},
      '{1, 4'h3, 8'h01}, '{1, 4'h2, 8'hff}, '{1, 4'h7, 8'h34},
      '{1, 4'h6, 8'h56}, '{1, 4'h5, 8'h55}, '{1, 4'h4, 8'h66},
      '{0, 4'h3, 8'h55}, '{0, 4'h7, 8'h34}, '{0, 4'h4, 8'h00},
      '{0, 4'h3, 8'h00}, '{0, 4'h2, 8'hff}, '{0, 4'h3, 8'h01},
      '{0, 4'ha, 8'h00}, '{0, 4'h9, 8'h00}
   };

   tcc_cpu_model cpu (.mclk(mclk), .bus_rdata(bus_rdata), .bus_req(bus_req));
   tcc_timer #(.TIMER_INDEX(1)) dut (.mclk(mclk), .arst_n(arst_n), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .ack_overflow(1'b0), .ack_capture(ack_capture),
      .tick_pin(tick_pin), .capture_pin(capture_pin), .comparator_out(comparator_out),
      .irq_overflow(irq_overflow), .irq_capture(irq_capture), .top_hit(top_hit),
      .bottom_hit(bottom_hit));

   // Compare one byte, four-state exact
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Watchdog: the tests need well under 2000 cycles
   initial begin
      #200000;
      err_count++;
      wrap_up();
   end

   initial begin
      arst_n = 1'b0;
      ack_capture = 1'b0;
      capture_pin = 1'b0;
      tick_pin = 1'b0;
      comparator_out = 1'b0;
      repeat (2) @(negedge mclk);
      arst_n = 1'b1;
      repeat (3) @(posedge mclk);
      foreach (rows[i]) begin
         if (rows[i].w) cpu.wr(rows[i].a, rows[i].d);
         else begin
            cpu.rd(rows[i].a, v);
            chk8(v, rows[i].d);
         end
      end
      $display("test done: register table");
      // Run every clock; write lands over the tick, then counts on
      cpu.wr(4'h1, 8'h01);
      cpu.wr(4'h3, 8'h00);
      cpu.wr(4'h2, 8'h10);
      cpu.rd(4'h2, v); chk8(v, 8'h11);
      cpu.rd(4'h2, v); chk8(v, 8'h13);
      // Source zero, rising capture edge selected
      cpu.wr(4'h1, 8'h40);
      cpu.rd(4'h2, u);
      chk8(u, 8'h16);
      cpu.rd(4'h2, v);
      chk8(v, 8'h16);
      $display("test done: counting");
      cpu.wr(4'h3, 8'h0a);
      cpu.wr(4'h2, 8'hbc);
      @(negedge mclk) capture_pin = 1'b1;
      repeat (6) @(negedge mclk);
      cpu.rd(4'h8, v); chk8(v, 8'h02);
      cpu.rd(4'h4, v); chk8(v, 8'hbc);
      cpu.rd(4'h5, v); chk8(v, 8'h0a);
      cpu.wr(4'h8, 8'h01);
      cpu.rd(4'h8, v); chk8(v, 8'h02);
      cpu.wr(4'h8, 8'h02);
      cpu.rd(4'h8, v); chk8(v, 8'h00);
      // Second capture replaces the first, already read value; interrupt enabled
      cpu.wr(4'h9, 8'h02);
      cpu.wr(4'h3, 8'h12);
      cpu.wr(4'h2, 8'h34);
      @(negedge mclk) capture_pin = 1'b0;
      repeat (3) @(negedge mclk);
      capture_pin = 1'b1;
      repeat (6) @(negedge mclk);
      chk8({7'h00, irq_capture}, 8'h01);
      cpu.rd(4'h4, v); chk8(v, 8'h34);
      @(negedge mclk) ack_capture = 1'b1;
      @(negedge mclk) ack_capture = 1'b0;
      repeat (2) @(negedge mclk);
      chk8({7'h00, irq_capture}, 8'h00);
      $display("test done: capture");
      // Fast 8-bit mode on external rising ticks: top, then overflow to zero
      cpu.wr(4'h0, 8'h01);
      cpu.wr(4'h3, 8'h00);
      cpu.wr(4'h2, 8'hfe);
      cpu.wr(4'h9, 8'h01);
      cpu.wr(4'h1, 8'h0f);
      for (int k = 0; k < 2; k++) begin
         tick_pin = 1'b1;
         repeat (4) @(negedge mclk);
         tick_pin = 1'b0;
         repeat (4) @(negedge mclk);
         chk8({6'h00, top_hit, bottom_hit}, (k == 0) ? 8'h02 : 8'h01);
      end
      chk8({7'h00, irq_overflow}, 8'h01);
      cpu.rd(4'h8, v);
      chk8(v, 8'h01);
      cpu.rd(4'h2, v);
      chk8(v, 8'h00);
      $display("test done: overflow");
      // Reset in mid-run with latch, overflow flag and capture all nonzero
      cpu.wr(4'h3, 8'h5a);
      capture_pin = 1'b0;
      arst_n = 1'b0;
      repeat (2) @(negedge mclk);
      arst_n = 1'b1;
      repeat (3) @(posedge mclk);
      cpu.rd(4'h3, v);
      chk8(v, 8'h00);
      chk8({7'h00, irq_overflow}, 8'h00);
      cpu.rd(4'h8, v);
      chk8(v, 8'h00);
      cpu.rd(4'h4, v);
      chk8(v, 8'h00);
      $display("test done: reset");
      // Comparator as capture source on the first instance, rising edge
      cpu.wr(4'h3, 8'h00);
      cpu.wr(4'h2, 8'h77);
      cpu.wr(4'h1, 8'h60);
      comparator_out = 1'b1;
      repeat (6) @(negedge mclk);
      cpu.rd(4'h4, v);
      chk8(v, 8'h77);
      cpu.rd(4'h8, v);
      chk8(v, 8'h02);
      $display("test done: comparator");
      wrap_up();
   end
endmodule
